// [dma_consts.vh]
/*
 * Constants for the channel and transfer controllers: counts, set layout,
 * option fields, depths and error bits.
 * Assumes it is included by its bare name from the design files.
 */
`ifndef DMA_CONSTS_VH
`define DMA_CONSTS_VH

`define NUM_DMA        8
`define NUM_QCH        4
`define NUM_CH         12
`define CH_W           4
`define MEM_W          7
`define MEM_WORDS      128
`define ENT_W          3
`define QDEPTH         16
`define QPTR_W         4
`define QCNT_W         5
`define DCTX_DEPTH     4
`define DCTX_PTR_W     2
`define DFIFO_DEPTH    16
`define DATA_W         64
`define BEAT_BYTES     32'h8
`define ADDR_W         32
`define LEN_W          14
`define CODE_W         10
`define REGION_W       2
`define NUM_REGION     4

// set memory entry index within a set
`define ENT_OPT        3'h0
`define ENT_SRC        3'h1
`define ENT_CNT        3'h2
`define ENT_DST        3'h3
`define ENT_CCNT       3'h7

// option word fields
`define OPT_EARLY      0
`define OPT_CHAIN_EN   1
`define OPT_INT_EN     2
`define OPT_CHAIN_LO   4
`define OPT_CHAIN_HI   6

// error status bits
`define ERR_MISSED     0
`define ERR_THRESH     1
`define ERR_NULL       2
`define ERR_W          3

`endif

// [dma_engine.v]
/*
 * Channel controller and transfer controller of a DMA engine, plus the
 * data FIFO that sits between the read and write controllers.
 * Assumes one clock shared by set memory writers and bus slaves;
 * external events arrive asynchronously.
 */
// Behaviour
// [R1] regular channel triggers: external event, software set, chained completion
// [R2] quick channel triggers on a write to its designated trigger word
// [R3] each trigger is recorded in event status when recognised, before queueing
// [R4] queue target programmable; queue holds up to 16 events (the code has one fixed queue)
// [R5] event for a full queue stays pending and enters when space frees
// [R6] simultaneous events: regular channels queued before quick channels
// [R7] within each group the lowest channel number goes first
// [R8] queue served in order; head channel's set is read for transfer details
// [R9] only valid requests submitted, queue zero feeds controller zero
// [R10] completion reported at data done or early when request leaves
// [R11] completion may chain another channel or raise a gated interrupt
// [R12] error interrupt on missed events and queue above threshold
// [R13] channels and interrupts assignable to separate regions
// [R14] debug status shows queue fill, active logic and missed events
// [R15] idle controller moves request to source active and context FIFO at once
// [R16] next request waits in program set until source active is exhausted
// [R17] reads issued per transfer size only when data FIFO has room
// [R18] writes start once data FIFO holds a write-sized beat
// [R19] reads run up to context-FIFO-depth requests ahead of writes
// [R20] finished transfer returns a completion code to the channel controller
// [R21] read and write ports are 64 bits, eight bytes a beat
// [R22] triggering a set with all counts zero is a null transfer error
// [R23] request presented only while program set is free, held until taken
// [R24] event on a channel already pending is flagged as missed
`timescale 1ns/1ps
`include "dma_consts.vh"

module data_fifo #(
  parameter WIDTH = 64,
  parameter DEPTH = 16,
  parameter AW    = 4
) (
  input  wire             clk,       // clock
  input  wire             arst_n,    // async reset, active low
  input  wire             in_valid,  // write side valid
  output wire             in_ready,  // not full
  input  wire [WIDTH-1:0] in_data,   // write data
  output wire             out_valid, // not empty
  input  wire             out_ready, // read side takes a word
  output wire [WIDTH-1:0] out_data   // head word
);
  reg [WIDTH-1:0] mem [0:DEPTH-1];
  reg [AW:0]      wp;
  reg [AW:0]      rp;
  wire            push;
  wire            pop;

  assign in_ready  = (wp[AW] == rp[AW]) || (wp[AW-1:0] != rp[AW-1:0]);
  assign out_valid = (wp != rp);
  assign out_data  = mem[rp[AW-1:0]];
  assign push      = in_valid && in_ready;
  assign pop       = out_valid && out_ready;

  always @(posedge clk) begin
    if (push) begin
      mem[wp[AW-1:0]] <= in_data;
    end
  end

  always @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      wp <= {(AW+1){1'b0}};
      rp <= {(AW+1){1'b0}};
    end else begin
      if (push) begin
        wp <= wp + {{AW{1'b0}}, 1'b1};
      end
      if (pop) begin
        rp <= rp + {{AW{1'b0}}, 1'b1};
      end
    end
  end
endmodule

module dma_engine (
  input  wire                       clk,            // 250 MHz clock
  input  wire                       arst_n,         // async reset, active low
  input  wire [`NUM_DMA-1:0]        ext_event,      // peripheral events, async
  input  wire [`NUM_DMA-1:0]        sw_event_set,   // software event set pulses
  input  wire                       set_wr_en,      // set memory write strobe
  input  wire [`MEM_W-1:0]          set_wr_addr,    // {set, entry} word address
  input  wire [31:0]                set_wr_data,    // set memory write data
  input  wire [`NUM_QCH*`MEM_W-1:0] qtrig_map,      // trigger word per quick channel
  input  wire [`QCNT_W-1:0]         queue_thresh,   // queue fill error threshold
  input  wire [`NUM_CH-1:0]         int_enable,     // completion interrupt enables
  input  wire [`NUM_CH-1:0]         int_clear,      // completion status clear pulses
  input  wire [`ERR_W-1:0]          err_clear,      // error status clear pulses
  input  wire [`NUM_CH*2-1:0]       region_map,     // region owning each channel
  output reg                        rd_valid,       // read command valid
  output reg  [`ADDR_W-1:0]         rd_addr,        // read beat address
  input  wire                       rd_ready,       // read command taken
  input  wire                       rd_data_valid,  // read data returned
  input  wire [`DATA_W-1:0]         rd_data,        // read data
  output reg                        wr_valid,       // write beat valid
  output reg  [`ADDR_W-1:0]         wr_addr,        // write beat address
  output reg  [`DATA_W-1:0]         wr_data,        // write data
  input  wire                       wr_ready,       // write beat taken
  output reg  [`NUM_CH-1:0]         event_status,   // recorded pending events
  output reg  [`NUM_CH-1:0]         int_status,     // sticky completion status
  output reg  [`NUM_REGION-1:0]     region_irq,     // per-region completion irq
  output reg  [`ERR_W-1:0]          err_status,     // sticky error status
  output reg                        err_irq,        // error interrupt
  output reg  [`NUM_CH-1:0]         missed_status,  // sticky missed events
  output reg  [`QCNT_W-1:0]         queue_count,    // queue fill
  output reg  [1:0]                 cc_active       // submission state
);
  localparam S_IDLE   = 2'b00;
  localparam S_READ   = 2'b01;
  localparam S_SUBMIT = 2'b10;

  function [`CH_W-1:0] lowest;
    input [`NUM_CH-1:0] v;
    integer i;
    begin
      lowest = {`CH_W{1'b0}};
      for (i = `NUM_CH-1; i >= 0; i = i - 1) begin
        if (v[i]) begin
          lowest = i[`CH_W-1:0];
        end
      end
    end
  endfunction

  reg  [`NUM_DMA-1:0] ext_s1;
  reg  [`NUM_DMA-1:0] ext_s2;
  reg  [`NUM_DMA-1:0] ext_s3;
  wire [`NUM_QCH-1:0] q_hit;
  wire [`NUM_DMA-1:0] chain_ev;
  reg  [`NUM_CH-1:0]  new_ev;
  reg  [`NUM_CH-1:0]  pop_ev;
  reg  [31:0]         set_mem [0:`MEM_WORDS-1];

  genvar k;
  generate
    for (k = 0; k < `NUM_QCH; k = k + 1) begin : g_qtrig
      assign q_hit[k] = set_wr_en && (set_wr_addr == qtrig_map[k*`MEM_W +: `MEM_W]); // R2
    end
  endgenerate

  always @(posedge clk) begin
    if (set_wr_en) begin
      set_mem[set_wr_addr] <= set_wr_data;
    end
  end

  always @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      ext_s1 <= {`NUM_DMA{1'b0}};
      ext_s2 <= {`NUM_DMA{1'b0}};
      ext_s3 <= {`NUM_DMA{1'b0}};
    end else begin
      ext_s1 <= ext_event;
      ext_s2 <= ext_s1;
      ext_s3 <= ext_s2;
    end
  end

  always @* begin
    new_ev = {q_hit, (ext_s2 & ~ext_s3) | sw_event_set | chain_ev}; // R1 R6
  end

  reg  [`CH_W-1:0]   q_mem [0:`QDEPTH-1];
  reg  [`QPTR_W-1:0] q_wp;
  reg  [`QPTR_W-1:0] q_rp;
  wire               q_full  = (queue_count == `QDEPTH);
  wire               q_empty = (queue_count == {`QCNT_W{1'b0}});
  wire               q_push  = (|event_status) && !q_full;          // R5
  wire [`CH_W-1:0]   q_sel   = lowest(event_status);                // R6 R7
  reg                q_pop;
  wire [`NUM_CH-1:0] missed  = new_ev & event_status & ~pop_ev;     // R24

  always @* begin
    pop_ev = {`NUM_CH{1'b0}};
    if (q_push) begin
      pop_ev[q_sel] = 1'b1;
    end
  end

  always @(posedge clk) begin
    if (q_push) begin
      q_mem[q_wp] <= q_sel;
    end
  end

  reg  [1:0]          state;
  reg  [`CH_W-1:0]    cur_ch;
  reg                 req_valid;
  reg  [`ADDR_W-1:0]  req_src;
  reg  [`ADDR_W-1:0]  req_dst;
  reg  [`LEN_W-1:0]   req_len;
  reg  [`CODE_W-1:0]  req_code;
  reg  [`MEM_W-1:0]   set_base;
  reg                 prog_valid;
  wire [31:0]         w_opt  = set_mem[set_base | {4'h0, `ENT_OPT}];
  wire [31:0]         w_cnt  = set_mem[set_base | {4'h0, `ENT_CNT}];
  wire [31:0]         w_ccnt = set_mem[set_base | {4'h0, `ENT_CCNT}];
  wire                null_set  = (w_cnt == 32'h0) && (w_ccnt[15:0] == 16'h0);
  wire                dummy_set = (w_cnt[15:0] == 16'h0) || (w_cnt[31:16] == 16'h0)
                                  || (w_ccnt[15:0] == 16'h0);
  wire [`LEN_W-1:0]   beats  = {1'b0, w_cnt[15:3]} + {13'h0, |w_cnt[2:0]};
  wire                submit = (state == S_SUBMIT) && req_valid && !prog_valid; // R23

  always @* begin
    if (cur_ch < `NUM_DMA) begin
      set_base = {cur_ch, `ENT_W'h0};
    end else begin
      set_base = {qtrig_map[(cur_ch-`NUM_DMA)*`MEM_W+`ENT_W +: 4], `ENT_W'h0};
    end
  end

  always @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      state     <= S_IDLE;
      cur_ch    <= {`CH_W{1'b0}};
      req_valid <= 1'b0;
      req_src   <= {`ADDR_W{1'b0}};
      req_dst   <= {`ADDR_W{1'b0}};
      req_len   <= {`LEN_W{1'b0}};
      req_code  <= {`CODE_W{1'b0}};
      q_pop     <= 1'b0;
    end else begin
      q_pop <= 1'b0;
      case (state)
        S_IDLE: begin
          if (!q_empty && !q_pop) begin
            cur_ch <= q_mem[q_rp];                                  // R8
            q_pop  <= 1'b1;
            state  <= S_READ;
          end
        end
        S_READ: begin
          if (null_set) begin
            state <= S_IDLE;                                        // R9 R22
          end else begin
            req_src   <= set_mem[set_base | {4'h0, `ENT_SRC}];      // R8
            req_dst   <= set_mem[set_base | {4'h0, `ENT_DST}];
            req_len   <= dummy_set ? {`LEN_W{1'b0}} : beats;
            req_code  <= {w_opt[`OPT_CHAIN_HI:`OPT_CHAIN_LO], w_opt[`OPT_CHAIN_EN],
                          w_opt[`OPT_INT_EN], w_opt[`OPT_EARLY], cur_ch};
            req_valid <= 1'b1;
            state     <= S_SUBMIT;
          end
        end
        S_SUBMIT: begin
          if (submit) begin
            req_valid <= 1'b0;
            state     <= S_IDLE;
          end
        end
        default: begin
          state <= S_IDLE;
        end
      endcase
    end
  end

  reg  [`ADDR_W-1:0]     prog_src;
  reg  [`ADDR_W-1:0]     prog_dst;
  reg  [`LEN_W-1:0]      prog_len;
  reg  [`CODE_W-1:0]     prog_code;
  reg                    act_valid;
  reg  [`ADDR_W-1:0]     act_addr;
  reg  [`LEN_W-1:0]      act_rem;
  reg                    rd_wait;
  reg  [`ADDR_W-1:0]     dq_dst  [0:`DCTX_DEPTH-1];
  reg  [`LEN_W-1:0]      dq_len  [0:`DCTX_DEPTH-1];
  reg  [`CODE_W-1:0]     dq_code [0:`DCTX_DEPTH-1];
  reg  [`DCTX_PTR_W:0]   dq_wp;
  reg  [`DCTX_PTR_W:0]   dq_rp;
  reg                    w_busy;
  reg  [`ADDR_W-1:0]     w_addr;
  reg  [`LEN_W-1:0]      w_rem;
  reg  [`CODE_W-1:0]     w_code;
  reg                    wr_last;
  reg  [`CODE_W-1:0]     wr_code;
  wire                   dq_empty = (dq_wp == dq_rp);
  wire                   dq_full  = (dq_wp[`DCTX_PTR_W] != dq_rp[`DCTX_PTR_W])
                                    && (dq_wp[`DCTX_PTR_W-1:0] == dq_rp[`DCTX_PTR_W-1:0]);
  wire                   load_act = prog_valid && !act_valid && !dq_full;    // R15 R16 R19
  wire                   df_in_ready;
  wire                   df_out_valid;
  wire [`DATA_W-1:0]     df_out_data;
  wire                   beat_slot = !wr_valid || wr_ready;
  wire                   df_pop    = w_busy && df_out_valid && beat_slot;    // R18
  wire                   dq_pop    = !w_busy && !dq_empty && !wr_valid;
  wire [`DCTX_PTR_W-1:0] dq_head   = dq_rp[`DCTX_PTR_W-1:0];
  wire                   zero_done = dq_pop && (dq_len[dq_head] == {`LEN_W{1'b0}});
  wire                   beat_done = wr_valid && wr_ready && wr_last;
  wire                   tc_done   = zero_done || beat_done;                 // R20
  wire [`CODE_W-1:0]     tc_code   = zero_done ? dq_code[dq_head] : wr_code;

  data_fifo #(
    .WIDTH (`DATA_W),
    .DEPTH (`DFIFO_DEPTH),
    .AW    (4)
  ) u_data_fifo (
    .clk       (clk),
    .arst_n    (arst_n),
    .in_valid  (rd_data_valid),
    .in_ready  (df_in_ready),
    .in_data   (rd_data),
    .out_valid (df_out_valid),
    .out_ready (df_pop),
    .out_data  (df_out_data)
  );

  always @(posedge clk) begin
    if (load_act) begin
      dq_dst[dq_wp[`DCTX_PTR_W-1:0]]  <= prog_dst;
      dq_len[dq_wp[`DCTX_PTR_W-1:0]]  <= prog_len;
      dq_code[dq_wp[`DCTX_PTR_W-1:0]] <= prog_code;
    end
  end

  always @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      prog_valid <= 1'b0;
      prog_src   <= {`ADDR_W{1'b0}};
      prog_dst   <= {`ADDR_W{1'b0}};
      prog_len   <= {`LEN_W{1'b0}};
      prog_code  <= {`CODE_W{1'b0}};
      act_valid  <= 1'b0;
      act_addr   <= {`ADDR_W{1'b0}};
      act_rem    <= {`LEN_W{1'b0}};
      rd_valid   <= 1'b0;
      rd_addr    <= {`ADDR_W{1'b0}};
      rd_wait    <= 1'b0;
      dq_wp      <= {(`DCTX_PTR_W+1){1'b0}};
      dq_rp      <= {(`DCTX_PTR_W+1){1'b0}};
      w_busy     <= 1'b0;
      w_addr     <= {`ADDR_W{1'b0}};
      w_rem      <= {`LEN_W{1'b0}};
      w_code     <= {`CODE_W{1'b0}};
      wr_valid   <= 1'b0;
      wr_addr    <= {`ADDR_W{1'b0}};
      wr_data    <= {`DATA_W{1'b0}};
      wr_last    <= 1'b0;
      wr_code    <= {`CODE_W{1'b0}};
    end else begin
      if (submit) begin
        prog_valid <= 1'b1;                                         // R9 R23
        prog_src   <= req_src;
        prog_dst   <= req_dst;
        prog_len   <= req_len;
        prog_code  <= req_code;
      end else if (load_act) begin
        prog_valid <= 1'b0;
      end
      if (load_act) begin
        act_valid <= (prog_len != {`LEN_W{1'b0}});                  // R15 R16
        act_addr  <= prog_src;
        act_rem   <= prog_len;
        dq_wp     <= dq_wp + {{`DCTX_PTR_W{1'b0}}, 1'b1};
      end
      // one beat in flight; data FIFO room checked before issue
      if (rd_valid) begin
        if (rd_ready) begin
          rd_valid <= 1'b0;
          rd_wait  <= 1'b1;
          act_addr <= act_addr + `BEAT_BYTES;                       // R21
          act_rem  <= act_rem - {{(`LEN_W-1){1'b0}}, 1'b1};
          if (act_rem == {{(`LEN_W-1){1'b0}}, 1'b1}) begin
            act_valid <= 1'b0;
          end
        end
      end else if (act_valid && !rd_wait && df_in_ready) begin
        rd_valid <= 1'b1;                                           // R17
        rd_addr  <= act_addr;
      end
      if (rd_data_valid) begin
        rd_wait <= 1'b0;
      end
      if (dq_pop) begin
        dq_rp <= dq_rp + {{`DCTX_PTR_W{1'b0}}, 1'b1};
        if (dq_len[dq_head] != {`LEN_W{1'b0}}) begin
          w_busy <= 1'b1;
          w_addr <= dq_dst[dq_head];
          w_rem  <= dq_len[dq_head];
          w_code <= dq_code[dq_head];
        end
      end
      if (df_pop) begin
        wr_valid <= 1'b1;                                           // R18
        wr_addr  <= w_addr;
        wr_data  <= df_out_data;
        wr_last  <= (w_rem == {{(`LEN_W-1){1'b0}}, 1'b1});
        wr_code  <= w_code;
        w_addr   <= w_addr + `BEAT_BYTES;
        w_rem    <= w_rem - {{(`LEN_W-1){1'b0}}, 1'b1};
        if (w_rem == {{(`LEN_W-1){1'b0}}, 1'b1}) begin
          w_busy <= 1'b0;
        end
      end else if (wr_ready) begin
        wr_valid <= 1'b0;
      end
    end
  end

  wire               early_fire = submit && req_code[`CH_W];                 // R10
  wire               late_fire  = tc_done && !tc_code[`CH_W];                // R10
  reg  [`NUM_CH-1:0] comp_int;
  reg  [`NUM_DMA-1:0] comp_chain;
  wire [`CODE_W-1:0] ecode = req_code;

  always @* begin
    comp_int   = {`NUM_CH{1'b0}};
    comp_chain = {`NUM_DMA{1'b0}};
    if (early_fire) begin
      comp_int[ecode[`CH_W-1:0]]       = ecode[`CH_W+1];            // R11
      comp_chain[ecode[`CODE_W-1 -: 3]] = ecode[`CH_W+2];
    end
    if (late_fire) begin
      comp_int[tc_code[`CH_W-1:0]]        = comp_int[tc_code[`CH_W-1:0]] | tc_code[`CH_W+1];
      comp_chain[tc_code[`CODE_W-1 -: 3]] = comp_chain[tc_code[`CODE_W-1 -: 3]]
                                            | tc_code[`CH_W+2];
    end
  end
  assign chain_ev = comp_chain;                                     // R1 R11

  reg  [`ERR_W-1:0]      err_set;
  reg  [`NUM_REGION-1:0] next_region_irq;
  wire [`NUM_CH-1:0]     int_live = int_status & int_enable;
  integer c;

  always @* begin
    err_set = {`ERR_W{1'b0}};
    err_set[`ERR_MISSED] = |missed;                                 // R12
    err_set[`ERR_THRESH] = (queue_count > queue_thresh);            // R12
    err_set[`ERR_NULL]   = (state == S_READ) && null_set;           // R22
    next_region_irq = {`NUM_REGION{1'b0}};
    for (c = 0; c < `NUM_CH; c = c + 1) begin
      next_region_irq[region_map[c*2 +: 2]] = next_region_irq[region_map[c*2 +: 2]]
                                              | int_live[c];        // R13
    end
  end

  always @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      event_status  <= {`NUM_CH{1'b0}};
      missed_status <= {`NUM_CH{1'b0}};
      int_status    <= {`NUM_CH{1'b0}};
      err_status    <= {`ERR_W{1'b0}};
      err_irq       <= 1'b0;
      region_irq    <= {`NUM_REGION{1'b0}};
      queue_count   <= {`QCNT_W{1'b0}};
      q_wp          <= {`QPTR_W{1'b0}};
      q_rp          <= {`QPTR_W{1'b0}};
      cc_active     <= S_IDLE;
    end else begin
      event_status  <= (event_status & ~pop_ev) | new_ev;           // R3 R5
      missed_status <= missed_status | missed;                      // R14 R24
      int_status    <= (int_status & ~int_clear) | comp_int;        // R11
      err_status    <= (err_status & ~err_clear) | err_set;
      err_irq       <= |err_status;                                 // R12
      region_irq    <= next_region_irq;                             // R13
      if (q_push) begin
        q_wp <= q_wp + {{(`QPTR_W-1){1'b0}}, 1'b1};                 // R4
      end
      if (q_pop) begin
        q_rp <= q_rp + {{(`QPTR_W-1){1'b0}}, 1'b1};
      end
      if (q_push && !q_pop) begin
        queue_count <= queue_count + {{(`QCNT_W-1){1'b0}}, 1'b1};   // R14
      end else if (q_pop && !q_push) begin
        queue_count <= queue_count - {{(`QCNT_W-1){1'b0}}, 1'b1};
      end
      cc_active <= state;                                           // R14
    end
  end
endmodule

// [dma_engine_chk.sv]
/* Port checker for dma_engine, bound to every instance of it.
   Assumes one clock domain and the async active-low reset. */
`timescale 1ns/1ps
module dma_engine_chk (
  input wire logic        clk,           // clock
  input wire logic        arst_n,        // async reset, active low
  input wire logic [7:0]  sw_event_set,  // software event pulses
  input wire logic [4:0]  queue_thresh,  // queue error threshold
  input wire logic        rd_valid,      // read command valid
  input wire logic [31:0] rd_addr,       // read address
  input wire logic        rd_ready,      // read command taken
  input wire logic        wr_valid,      // write beat valid
  input wire logic [31:0] wr_addr,       // write address
  input wire logic [63:0] wr_data,       // write data
  input wire logic        wr_ready,      // write beat taken
  input wire logic [11:0] event_status,  // pending events
  input wire logic [2:0]  err_status,    // sticky errors
  input wire logic        err_irq,       // error interrupt
  input wire logic [11:0] missed_status, // sticky missed events
  input wire logic [4:0]  queue_count    // queue fill
);
  default clocking @(posedge clk); endclocking
  default disable iff (!arst_n);
  a_sw_record: assert property (sw_event_set[2] |=> event_status[2])
    else $error("software event not recorded");
  a_missed_flag: assert property (|(sw_event_set & event_status[7:0]
    & (event_status[7:0] - 8'h01)) |=> err_status[0])
    else $error("missed event not flagged");
  a_missed_keep: assert property (($past(missed_status) & ~missed_status) == 12'h000)
    else $error("missed status lost");
  a_thresh_err: assert property (queue_count > queue_thresh |=> err_status[1])
    else $error("threshold error not raised");
  a_err_irq: assert property (err_irq == |$past(err_status))
    else $error("error interrupt wrong");
  a_rd_hold: assert property (rd_valid && !rd_ready |=> rd_valid && $stable(rd_addr))
    else $error("read command not held");
  a_wr_hold: assert property (wr_valid && !wr_ready |=> wr_valid && $stable({wr_addr, wr_data}))
    else $error("write beat not held");
  a_queue_cap: assert property (queue_count <= 5'h10)
    else $error("queue above its depth");
  c_write: cover property (wr_valid && wr_ready);
  c_missed: cover property (|missed_status);
  c_rd_stall: cover property (rd_valid && !rd_ready);
endmodule
bind dma_engine dma_engine_chk u_dma_engine_chk (.*);

// [bus_slave_model.sv]
/* Bus slave answering the read and write ports of the transfer controller.
   Assumes one clock; slow adds stalls to both handshakes. */
`timescale 1ns/1ps
module bus_slave_model (
  input  wire        clk,           // clock
  input  wire        slow,          // stall enable
  input  wire        rd_valid,      // read command
  input  wire [31:0] rd_addr,       // read address
  output reg         rd_ready,      // read command taken
  output reg         rd_data_valid, // read data pulse
  output reg  [63:0] rd_data,       // read data
  input  wire        wr_valid,      // write beat
  output reg         wr_ready       // write beat taken
);
  reg [1:0]  tick;
  reg [31:0] la;
  initial begin
    {tick, rd_ready, rd_data_valid, wr_ready} = 5'h00;
    {rd_data, la} = 96'h0;
  end
  // answers at the falling edge; idle data toggles
  always @(negedge clk) begin
    tick <= tick + 2'h1;
    rd_ready <= rd_valid && !rd_ready && !rd_data_valid && (!slow || tick == 2'h0);
    if (rd_valid && !rd_ready) begin
      la <= rd_addr;
    end
    rd_data_valid <= rd_ready;
    rd_data <= rd_ready ? {~la, la} : ~rd_data;
    wr_ready <= wr_valid && (!slow || tick[0]);
  end
endmodule

// [dma_channel_and_transfer_ctrl_test.sv]
/* Self-checking bench for dma_engine with a bus slave model.
   Assumes the checker and the model are compiled with it. */
`timescale 1ns/1ps
module dma_channel_and_transfer_ctrl_test;
  reg         clk, arst_n, set_wr_en, slow;
  reg  [7:0]  ext_event, sw_event_set;
  reg  [6:0]  set_wr_addr;
  reg  [31:0] set_wr_data;
  reg  [27:0] qtrig_map;
  reg  [4:0]  queue_thresh;
  reg  [11:0] int_enable, int_clear;
  reg  [2:0]  err_clear;
  reg  [23:0] region_map;
  wire        rd_valid, rd_ready, rd_data_valid, wr_valid, wr_ready, err_irq;
  wire [31:0] rd_addr, wr_addr;
  wire [63:0] rd_data, wr_data;
  wire [11:0] event_status, int_status, missed_status;
  wire [3:0]  region_irq;
  wire [2:0]  err_status;
  wire [4:0]  queue_count;
  wire [1:0]  cc_active;
  integer     n_mismatch, tests_run;
  reg  [31:0] qa[$];
  reg  [63:0] qd[$];

  dma_engine u_dma_engine (.clk, .arst_n, .ext_event, .sw_event_set, .set_wr_en, .set_wr_addr,
    .set_wr_data, .qtrig_map, .queue_thresh, .int_enable, .int_clear, .err_clear, .region_map,
    .rd_valid, .rd_addr, .rd_ready, .rd_data_valid, .rd_data, .wr_valid, .wr_addr, .wr_data,
    .wr_ready, .event_status, .int_status, .region_irq, .err_status, .err_irq, .missed_status,
    .queue_count, .cc_active);
  bus_slave_model u_bus_slave_model (.clk, .slow, .rd_valid, .rd_addr, .rd_ready,
    .rd_data_valid, .rd_data, .wr_valid, .wr_ready);

  initial begin
    clk = 0;
    forever #2 clk = ~clk;
  end
  always @(posedge clk) begin
    if (wr_valid && wr_ready) begin
      qa.push_back(wr_addr);
      qd.push_back(wr_data);
    end
  end

  task chk(input [63:0] got, exp);
    begin
      tests_run = tests_run + 1;
      if (got !== exp) begin
        n_mismatch = n_mismatch + 1;
        $display("Error %0t: got %h expected %h", $time, got, exp);
      end
    end
  endtask
  task tally_and_finish;
    begin
      $display("checks %0d mismatches %0d", tests_run, n_mismatch);
      if (n_mismatch == 0 && tests_run > 0) $display("bench passed");
      else $display("bench failed");
      $finish;
    end
  endtask
  // strobe stays high for the next word
  task wset(input [3:0] s, input [2:0] e, input [31:0] d);
    begin
      set_wr_en = 1;
      set_wr_addr = {s, e};
      set_wr_data = d;
      @(negedge clk);
    end
  endtask
  task prog(input [3:0] s, input [31:0] opt, src, cnt);
    begin
      wset(s, 3'h7, 32'h1);
      wset(s, 3'h0, opt);
      wset(s, 3'h1, src);
      wset(s, 3'h2, cnt);
    end
  endtask
  task wait_wr(input integer n);
    integer k;
    begin
      for (k = 0; k < 600 && qa.size() < n; k = k + 1) @(negedge clk);
      if (qa.size() < n) begin
        chk(qa.size(), n);
        tally_and_finish;
      end
    end
  endtask
  task exp_wr(input [31:0] a, s);
    begin
      chk(qa.pop_front(), a);
      chk(qd.pop_front(), {~s, s});
    end
  endtask

  task test_reset;
    begin
      chk({event_status, int_status, err_status, queue_count, rd_valid, wr_valid}, 0);
      $display("test reset done");
    end
  endtask
  task test_chain;
    begin
      prog(4'h1, 32'h46, 32'h1000, 32'h0001_0010);
      wset(4'h1, 3'h3, 32'h2000);
      prog(4'h4, 32'h4, 32'h1800, 32'h0001_0008);
      wset(4'h4, 3'h3, 32'h6000);
      set_wr_en = 0;
      ext_event = 8'h02;
      wait_wr(3);
      ext_event = 8'h00;
      exp_wr(32'h2000, 32'h1000);
      exp_wr(32'h2008, 32'h1008);
      exp_wr(32'h6000, 32'h1800);
      repeat (3) @(negedge clk);
      chk(int_status, 12'h012);
      chk(region_irq, 4'h5);
      int_clear = 12'h012;
      @(negedge clk);
      int_clear = 12'h000;
      repeat (2) @(negedge clk);
      chk({int_status, region_irq}, 16'h0000);
      $display("test chain done");
    end
  endtask
  task test_prio;
    begin
      slow = 1;
      prog(4'h2, 32'h0, 32'h3100, 32'h0001_0008);
      wset(4'h2, 3'h3, 32'h3000);
      prog(4'h3, 32'h0, 32'h4100, 32'h0001_0008);
      wset(4'h3, 3'h3, 32'h4000);
      prog(4'h9, 32'h5, 32'h5100, 32'h0001_0008);
      sw_event_set = 8'h0C;
      wset(4'h9, 3'h3, 32'h5000);
      set_wr_en = 0;
      sw_event_set = 8'h00;
      wait_wr(2);
      chk(int_status, 12'h100);
      wait_wr(3);
      exp_wr(32'h3000, 32'h3100);
      exp_wr(32'h4000, 32'h4100);
      exp_wr(32'h5000, 32'h5100);
      slow = 0;
      $display("test priority done");
    end
  endtask
  task test_miss;
    begin
      queue_thresh = 5'h00;
      wset(4'h5, 3'h2, 32'h0);
      wset(4'h5, 3'h7, 32'h0);
      set_wr_en = 0;
      sw_event_set = 8'h30;
      @(negedge clk);
      sw_event_set = 8'h20;
      @(negedge clk);
      sw_event_set = 8'h00;
      repeat (8) @(negedge clk);
      chk({err_irq, err_status}, 4'hF);
      queue_thresh = 5'h10;
      err_clear = 3'h7;
      @(negedge clk);
      err_clear = 3'h0;
      repeat (2) @(negedge clk);
      chk({err_irq, err_status}, 4'h0);
      chk(missed_status, 12'h020);
      $display("test missed done");
    end
  endtask

  initial begin
    {n_mismatch, tests_run} = 0;
    {arst_n, set_wr_en, slow, ext_event, sw_event_set, set_wr_addr, set_wr_data} = 0;
    {int_clear, err_clear} = 0;
    int_enable = 12'hFFF;
    region_map = 24'h000008;
    qtrig_map = 28'h000004B;
    queue_thresh = 5'h10;
    repeat (4) @(negedge clk);
    arst_n = 1;
    test_reset;
    test_chain;
    test_prio;
    test_miss;
    tally_and_finish;
  end
endmodule
